//--- logic/aasy_axis.sv
// Axis alarm handling and synchronous start logic
// Overview of operation
// - Active alarm during a constant-speed run stops output pulses at once.
// - Stop-method bit: 0 immediate, 1 decelerate only after high speed start.
// - Alarm active when start is written: no pulses for that start.
// - Alarm recognised after 80 cycles filtered, 2 cycles unfiltered.
// - Config bit 26 enables the alarm filter; short pulses are ignored.
// - Config bit 9 sets alarm polarity: 0 low-active, 1 high-active.
// - Sub-status bit 11 shows the alarm is active.
// - Stop-cause bit 7 marks a stop caused by the alarm.
// - Start mode 01 at bits 18-19 starts feeding when start line low.
// - Start line is always active low.
// - Start-line event interrupt sets cause bit and interrupt output.
// - Extension status shows waiting state and start line level.
// - Synchronous start command pulls the line low for 8 cycles.
// - Start line only pulled down, open-collector style.
// - Level or edge trigger; level mode starts at once if line already low.
// - Own start command still starts the axis independently.
// - Immediate stop command 49h cancels the waiting state.
// - All waiting axes start in the same cycle, three clock edges after the line activates, through the synchroniser.
// - Config bit 18 selects trigger: 0 level, 1 edge.
// - Operation state reads 0010 while waiting for the start line.
`timescale 1ns/1ns
`include "aasy_regs.svh"
module aasy_axis
	import aasy_pkg::*;
#(
	parameter int SYNC_PULSE_CYC = `AASY_SYNC_PULSE_CYC,
	parameter int DECEL_CYC      = `AASY_DECEL_CYC
) (
	input  wire logic            MCLK,
	input  wire logic            RSTN,
	input  wire aasy_pkg::aasy_addr_t ADDR,
	input  wire aasy_pkg::aasy_data_t WDATA,
	input  wire logic            WR,
	input  wire logic            RD,
	output aasy_pkg::aasy_data_t RDATA,
	input  wire logic            ALARM_IN,
	input  wire logic            START_LINE_I,
	output logic                 START_LINE_O,
	output logic                 START_LINE_OE,
	output logic                 PULSE_EN,
	output logic                 INT_N
);
	import aasy_pkg::*;

	initial begin
		if (SYNC_PULSE_CYC < 1 || SYNC_PULSE_CYC > 255 || DECEL_CYC < 1 || DECEL_CYC > 65535)
			$error("bad timing parameters");
	end

	aasy_state_e state;
	aasy_state_e next_state;
	logic [31:0] env1;
	logic [1:0]  start_mode;
	logic        irq_start_en;
	logic        irq_start_cause;
	logic        speed_high;
	logic        stop_alarm;
	logic        alarm_act;
	logic        sl_s1;
	logic        sl_s2;
	logic        sl_prev;
	logic        line_low;
	logic        line_fall;
	logic        trig;
	logic [7:0]  sync_cnt;
	logic [15:0] decel_cnt;
	logic        wr_cmd;
	logic        cmd_start;
	logic        cmd_stop;
	logic        cmd_sync;
	logic [3:0]  op_state;

	aasy_filt_if fif ();

	// ==========================================================
	// Alarm qualification
	assign fif.raw     = ALARM_IN ~^ env1[`AASY_ENV1_ALM_POL];
	assign fif.filt_on = env1[`AASY_ENV1_ALM_FILT];
	assign alarm_act   = fif.active;

	aasy_alarm_filt u_filt (
		.clk   (MCLK),
		.rst_n (RSTN),
		.fi    (fif)
	);

	// ==========================================================
	// Start line synchroniser and trigger
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			sl_s1   <= 1'b1;
			sl_s2   <= 1'b1;
			sl_prev <= 1'b1;
		end else begin
			sl_s1   <= START_LINE_I;
			sl_s2   <= sl_s1;
			sl_prev <= sl_s2;
		end
	end

	assign line_low  = !sl_s2;
	assign line_fall = sl_prev && !sl_s2;
	assign trig      = env1[`AASY_ENV1_START_EDGE] ? line_fall : line_low;

	// ==========================================================
	// Register writes
	assign wr_cmd    = WR && (ADDR == `AASY_OFS_CMD);
	assign cmd_start = wr_cmd && (WDATA[7:0] == `AASY_CMD_START);
	assign cmd_stop  = wr_cmd && (WDATA[7:0] == `AASY_CMD_STOP_NOW);
	assign cmd_sync  = wr_cmd && (WDATA[7:0] == `AASY_CMD_SYNC_START);

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			env1         <= `AASY_ENV1_RESET;
			start_mode   <= 2'h0;
			irq_start_en <= 1'b0;
			speed_high   <= 1'b0;
		end else if (WR) begin
			unique case (ADDR)
				`AASY_OFS_ENV1:   env1         <= WDATA;
				`AASY_OFS_MODE:   start_mode   <= WDATA[`AASY_MODE_START_LO+1:`AASY_MODE_START_LO];
				`AASY_OFS_IRQ_EN: irq_start_en <= WDATA[`AASY_IRQ_START_EN];
				`AASY_OFS_SPEED:  speed_high   <= WDATA[`AASY_SPEED_HIGH];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Axis state machine
	always_comb begin
		next_state = state;
		unique case (state)
			AASY_IDLE: begin
				if (cmd_start && !alarm_act) begin
					if (start_mode == `AASY_START_WAIT_CODE)
						next_state = AASY_WAIT;
					else
						next_state = AASY_RUN;
				end
			end
			AASY_WAIT: begin
				if (cmd_stop)
					next_state = AASY_IDLE;
				else if (alarm_act)
					next_state = AASY_IDLE;
				else if (trig)
					next_state = AASY_RUN;
			end
			AASY_RUN: begin
				if (cmd_stop)
					next_state = AASY_IDLE;
				else if (alarm_act) begin
					if (env1[`AASY_ENV1_ALM_STOP] && speed_high)
						next_state = AASY_DECEL;
					else
						next_state = AASY_IDLE;
				end
			end
			AASY_DECEL: begin
				if (cmd_stop || decel_cnt == 16'h0000)
					next_state = AASY_IDLE;
			end
		endcase
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) state <= AASY_IDLE;
		else       state <= next_state;
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN)
			decel_cnt <= 16'h0000;
		else if (state == AASY_RUN)
			decel_cnt <= 16'(DECEL_CYC - 1);
		else if (state == AASY_DECEL && decel_cnt != 16'h0000)
			decel_cnt <= decel_cnt - 16'h0001;
	end

	assign PULSE_EN = (state == AASY_RUN) || (state == AASY_DECEL);

	// ==========================================================
	// Stop cause
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN)
			stop_alarm <= 1'b0;
		else if ((state == AASY_RUN || state == AASY_DECEL) && next_state == AASY_IDLE)
			stop_alarm <= alarm_act && !cmd_stop;
		else if (cmd_start)
			stop_alarm <= alarm_act;
	end

	// ==========================================================
	// Synchronous start pulse, pull-down only
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN)
			sync_cnt <= 8'h00;
		else if (cmd_sync)
			sync_cnt <= 8'(SYNC_PULSE_CYC);
		else if (sync_cnt != 8'h00)
			sync_cnt <= sync_cnt - 8'h01;
	end

	assign START_LINE_O  = 1'b0;
	assign START_LINE_OE = (sync_cnt != 8'h00);

	// ==========================================================
	// Event interrupt, set wins over the clear by writing one to the cause bit
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN)
			irq_start_cause <= 1'b0;
		else if (irq_start_en && line_fall)
			irq_start_cause <= 1'b1;
		else if (WR && ADDR == `AASY_OFS_IRQ_CAUSE && WDATA[`AASY_IRQ_START_CAUSE])
			irq_start_cause <= 1'b0;
	end

	assign INT_N = !irq_start_cause;

	// ==========================================================
	// Read data
	always_comb begin
		unique case (state)
			AASY_WAIT:  op_state = `AASY_OPST_WAIT_START;
			AASY_RUN:   op_state = `AASY_OPST_RUN;
			AASY_DECEL: op_state = `AASY_OPST_DECEL;
			default:    op_state = `AASY_OPST_IDLE;
		endcase
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN)
			RDATA <= 32'h0000_0000;
		else begin
			RDATA <= 32'h0000_0000;
			if (RD) begin
				unique case (ADDR)
					`AASY_OFS_MODE:      RDATA[`AASY_MODE_START_LO+1:`AASY_MODE_START_LO] <= start_mode;
					`AASY_OFS_IRQ_EN:    RDATA[`AASY_IRQ_START_EN] <= irq_start_en;
					`AASY_OFS_IRQ_CAUSE: RDATA[`AASY_IRQ_START_CAUSE] <= irq_start_cause;
					`AASY_OFS_SUBSTAT:   RDATA[`AASY_SUB_ALARM] <= alarm_act;
					`AASY_OFS_STOPCAUSE: RDATA[`AASY_STOP_ALARM] <= stop_alarm;
					`AASY_OFS_EXTSTAT: begin
						RDATA[3:0] <= op_state;
						RDATA[`AASY_EXT_START_LEVEL] <= line_low;
					end
					`AASY_OFS_SPEED:     RDATA[`AASY_SPEED_HIGH] <= speed_high;
					default: ;
				endcase
			end
		end
	end

	// ==========================================================
	// Assertions
	a_alarm_immediate_stop: assert property (@(posedge MCLK) disable iff (!RSTN)
		(state == AASY_RUN && alarm_act && !env1[`AASY_ENV1_ALM_STOP]) |=> !PULSE_EN)
		else $error("alarm did not stop axis immediately");

	a_alarm_decel_stop: assert property (@(posedge MCLK) disable iff (!RSTN)
		(state == AASY_RUN && alarm_act && !cmd_stop && env1[`AASY_ENV1_ALM_STOP] && speed_high)
		|=> state == AASY_DECEL)
		else $error("decelerating stop not taken");

	a_start_blocked_alarm: assert property (@(posedge MCLK) disable iff (!RSTN)
		(state == AASY_IDLE && cmd_start && alarm_act) |=> !PULSE_EN)
		else $error("pulses after start during alarm");

	a_sync_pulse_len: assert property (@(posedge MCLK) disable iff (!RSTN)
		(cmd_sync && sync_cnt == 8'h00) |=> START_LINE_OE [*8] ##1 (!START_LINE_OE || $past(cmd_sync)))
		else $error("sync start pulse not eight cycles");

	a_pull_down_only: assert property (@(posedge MCLK) disable iff (!RSTN)
		START_LINE_OE |-> !START_LINE_O)
		else $error("start line driven high");

	a_wait_stop_cancel: assert property (@(posedge MCLK) disable iff (!RSTN)
		(state == AASY_WAIT && cmd_stop) |=> state == AASY_IDLE)
		else $error("stop did not cancel wait");

	a_wait_level_start: assert property (@(posedge MCLK) disable iff (!RSTN)
		(state == AASY_WAIT && !env1[`AASY_ENV1_START_EDGE] && line_low && !alarm_act && !cmd_stop)
		|=> PULSE_EN)
		else $error("waiting axis did not start on line");

	a_wait_code: assert property (@(posedge MCLK) disable iff (!RSTN)
		(state == AASY_WAIT && RD && ADDR == `AASY_OFS_EXTSTAT) |=> RDATA[3:0] == `AASY_OPST_WAIT_START)
		else $error("wait code wrong");

	a_int_follows_cause: assert property (@(posedge MCLK) disable iff (!RSTN)
		(irq_start_en && line_fall) |=> !INT_N)
		else $error("start line interrupt missing");

	a_alarm_status_bit: assert property (@(posedge MCLK) disable iff (!RSTN)
		(RD && ADDR == `AASY_OFS_SUBSTAT) |=> RDATA[`AASY_SUB_ALARM] == $past(alarm_act))
		else $error("alarm status bit wrong");

	a_stop_cause_alarm: assert property (@(posedge MCLK) disable iff (!RSTN)
		((state == AASY_RUN || state == AASY_DECEL) && next_state == AASY_IDLE && alarm_act && !cmd_stop)
		|=> stop_alarm)
		else $error("alarm stop not recorded");

	a_wait_entry: assert property (@(posedge MCLK) disable iff (!RSTN)
		(state == AASY_IDLE && cmd_start && !alarm_act && start_mode == `AASY_START_WAIT_CODE)
		|=> state == AASY_WAIT)
		else $error("start in wait mode did not wait");

	a_own_start: assert property (@(posedge MCLK) disable iff (!RSTN)
		(state == AASY_IDLE && cmd_start && !alarm_act && start_mode != `AASY_START_WAIT_CODE) |=> PULSE_EN)
		else $error("own start command ignored");

	a_idle_no_pulse: assert property (@(posedge MCLK) disable iff (!RSTN)
		(state == AASY_IDLE && !cmd_start) |=> !PULSE_EN)
		else $error("axis started without command");

	a_alarm_wait_exit: assert property (@(posedge MCLK) disable iff (!RSTN)
		(state == AASY_WAIT && alarm_act && !cmd_stop) |=> state == AASY_IDLE)
		else $error("waiting axis kept waiting during alarm");

	a_edge_needs_fall: assert property (@(posedge MCLK) disable iff (!RSTN)
		(state == AASY_WAIT && env1[`AASY_ENV1_START_EDGE] && !line_fall) |=> state != AASY_RUN)
		else $error("edge mode started without falling edge");

	a_line_level_status: assert property (@(posedge MCLK) disable iff (!RSTN)
		(RD && ADDR == `AASY_OFS_EXTSTAT) |=> RDATA[`AASY_EXT_START_LEVEL] == $past(line_low))
		else $error("start line level status wrong");

	a_start_line_sync: assert property (@(posedge MCLK) disable iff (!RSTN)
		($past(RSTN, 1) && $past(RSTN, 2)) |-> line_low == !$past(START_LINE_I, 2))
		else $error("start line not seen through two flip-flops");

	a_int_clear: assert property (@(posedge MCLK) disable iff (!RSTN)
		(WR && ADDR == `AASY_OFS_IRQ_CAUSE && WDATA[`AASY_IRQ_START_CAUSE] && !(irq_start_en && line_fall))
		|=> INT_N)
		else $error("interrupt cause not cleared");

	a_decel_run_out: assert property (@(posedge MCLK) disable iff (!RSTN)
		(state == AASY_DECEL && decel_cnt == 16'h0000) |=> state == AASY_IDLE)
		else $error("deceleration did not end");
endmodule : aasy_axis

//--- logic/aasy_regs.svh
// Register offsets, field positions and timing counts of the axis alarm and synchronous start block
`ifndef AASY_REGS_SVH
`define AASY_REGS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define AASY_OFS_ENV1      8'h00
`define AASY_OFS_MODE      8'h04
`define AASY_OFS_CMD       8'h08
`define AASY_OFS_IRQ_EN    8'h0C
`define AASY_OFS_IRQ_CAUSE 8'h10
`define AASY_OFS_SUBSTAT   8'h14
`define AASY_OFS_STOPCAUSE 8'h18
`define AASY_OFS_EXTSTAT   8'h1C
`define AASY_OFS_SPEED     8'h20

// ==========================================================
// Field positions
`define AASY_ENV1_ALM_STOP   8
`define AASY_ENV1_ALM_POL    9
`define AASY_ENV1_START_EDGE 18
`define AASY_ENV1_ALM_FILT   26
`define AASY_MODE_START_LO   18
`define AASY_IRQ_START_EN    18
`define AASY_IRQ_START_CAUSE 19
`define AASY_SUB_ALARM       11
`define AASY_STOP_ALARM      7
`define AASY_EXT_START_LEVEL 5
`define AASY_SPEED_HIGH      0

// ==========================================================
// Codes and reset values
`define AASY_START_WAIT_CODE 2'h1
`define AASY_CMD_START       8'h50
`define AASY_CMD_STOP_NOW    8'h49
`define AASY_CMD_SYNC_START  8'h06
`define AASY_OPST_IDLE       4'h0
`define AASY_OPST_WAIT_START 4'h2
`define AASY_OPST_RUN        4'h1
`define AASY_OPST_DECEL      4'h3
`define AASY_ENV1_RESET      32'h0000_0000

// ==========================================================
// Timing: period and figures in ns, counts in cycles
`define AASY_CLK_NS          4
`define AASY_ALM_FILT_NS     320
`define AASY_ALM_FILT_CYC    ((`AASY_ALM_FILT_NS + `AASY_CLK_NS - 1) / `AASY_CLK_NS)
`define AASY_ALM_RAW_CYC     2
`define AASY_SYNC_PULSE_CYC  8
`define AASY_DECEL_CYC       16

`endif

//--- logic/aasy_pkg.sv
// Types shared by the axis alarm and synchronous start block
package aasy_pkg;
	typedef enum logic [1:0] {
		AASY_IDLE  = 2'h0,
		AASY_WAIT  = 2'h1,
		AASY_RUN   = 2'h2,
		AASY_DECEL = 2'h3
	} aasy_state_e;
	typedef logic [7:0]  aasy_addr_t;
	typedef logic [31:0] aasy_data_t;
endpackage : aasy_pkg

//--- logic/aasy_filt_if.sv
// Interface between the axis core and the alarm filter
`timescale 1ns/1ns
interface aasy_filt_if;
	logic raw;
	logic filt_on;
	logic active;
	modport core (output raw, output filt_on, input active);
	modport filt (input raw, input filt_on, output active);
endinterface : aasy_filt_if

//--- logic/aasy_alarm_filt.sv
// Alarm input synchroniser and width filter
`timescale 1ns/1ns
`include "aasy_regs.svh"
module aasy_alarm_filt #(
	parameter int FILT_CYC = `AASY_ALM_FILT_CYC,
	parameter int RAW_CYC  = `AASY_ALM_RAW_CYC
) (
	input wire logic      clk,
	input wire logic      rst_n,
	aasy_filt_if.filt     fi
);
	localparam int CW = $clog2(FILT_CYC + 1);
	logic          sync1;
	logic          sync2;
	logic [CW-1:0] cnt;
	logic [CW-1:0] need;

	initial begin
		if (FILT_CYC < 2 || RAW_CYC < 2 || RAW_CYC > FILT_CYC) $error("bad filter counts");
	end

	// ==========================================================
	// Synchroniser
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
		end else begin
			sync1 <= fi.raw;
			sync2 <= sync1;
		end
	end

	// ==========================================================
	// Width qualifier: active after FILT_CYC (filter on) or RAW_CYC cycles of steady level, counting the synchroniser
	assign need = fi.filt_on ? CW'(FILT_CYC - 2) : CW'(RAW_CYC - 2);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt       <= '0;
			fi.active <= 1'b0;
		end else if (sync2 == fi.active) begin
			cnt <= '0;
		end else if (cnt >= need) begin
			cnt       <= '0;
			fi.active <= sync2;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end

	a_filter_short_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(fi.active) |-> $past(sync2, 1))
		else $error("alarm qualified without steady input");
endmodule : aasy_alarm_filt

//--- verification/aasy_partner.sv
// Partner model: servo driver alarm output and the shared start wire of other controllers
`timescale 1ns/1ns
module aasy_partner #(
	parameter int SHOT_CYC = 4
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic alm_on,
	input  wire logic alm_pol,
	input  wire logic ext_low,
	input  wire logic ext_shot,
	input  wire logic dut_oe,
	output logic      alarm_in,
	output logic      line
);
	int shot_cnt;

	// ==========================================================
	// External one-shot trigger circuit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shot_cnt <= 0;
		end else if (ext_shot) begin
			shot_cnt <= SHOT_CYC;
		end else if (shot_cnt > 0) begin
			shot_cnt <= shot_cnt - 1;
		end
	end

	// ==========================================================
	// Alarm stays up for as long as the bench holds alm_on
	assign alarm_in = alm_pol ? alm_on : !alm_on;
	// Wire has a pull-up; every party only pulls it down
	assign line = (dut_oe || ext_low || shot_cnt > 0) ? 1'b0 : 1'b1;
endmodule : aasy_partner

//--- verification/test_axis_alarm_and_sync_start.sv
// Self-checking testbench of the axis alarm and synchronous start block
`timescale 1ns/1ns
`include "aasy_regs.svh"
module test_axis_alarm_and_sync_start;
	import aasy_pkg::*;
	logic       mclk, rstn, wr_s, rd_s, alm_on, alm_pol, ext_low, ext_shot;
	logic       alarm_in, line, line_o, line_oe, pulse_en, int_n;
	aasy_addr_t addr;
	aasy_data_t wdata, rdata, d;
	int         n_mismatch, checks_done, cyc;

	aasy_axis #(.SYNC_PULSE_CYC(8), .DECEL_CYC(12)) i_aasy_axis (.MCLK(mclk), .RSTN(rstn), .ADDR(addr),
		.WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata), .ALARM_IN(alarm_in), .START_LINE_I(line),
		.START_LINE_O(line_o), .START_LINE_OE(line_oe), .PULSE_EN(pulse_en), .INT_N(int_n));
	aasy_partner #(.SHOT_CYC(4)) i_aasy_partner (.clk(mclk), .rst_n(rstn), .alm_on(alm_on), .alm_pol(alm_pol),
		.ext_low(ext_low), .ext_shot(ext_shot), .dut_oe(line_oe), .alarm_in(alarm_in), .line(line));

	always #2 mclk = ~mclk;

	// ==========================================================
	// Shared tasks
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic bus_wr(input aasy_addr_t a, input aasy_data_t v);
		@(posedge mclk);
		addr  <= a;
		wdata <= v;
		wr_s  <= 1'b1;
		@(posedge mclk);
		wr_s <= 1'b0;
	endtask : bus_wr

	task automatic bus_rd(input aasy_addr_t a);
		@(posedge mclk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge mclk);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask : bus_rd

	task automatic cmd(input logic [7:0] c);
		bus_wr(`AASY_OFS_CMD, {24'h000000, c});
	endtask : cmd

	task automatic rbit(input aasy_addr_t a, input int n, input logic [31:0] exp);
		bus_rd(a);
		chk({31'h0, d[n]}, exp);
	endtask : rbit

	task automatic wait_pe(input logic v, input int hi);
		int n;
		n = 0;
		while (pulse_en !== v && n < hi) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk({31'h0, pulse_en}, {31'h0, v});
	endtask : wait_pe

	task automatic set_alarm(input logic v);
		@(posedge mclk);
		alm_on <= v;
	endtask : set_alarm

	task automatic idle;
		set_alarm(1'b0);
		cmd(`AASY_CMD_STOP_NOW);
		repeat (4) @(posedge mclk);
	endtask : idle

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		chk({29'h0, pulse_en, int_n, line_oe}, 32'h2);
		bus_rd(`AASY_OFS_ENV1);
		chk(d, 32'h0);
		bus_wr(8'h40, 32'hFFFFFFFF);
		bus_rd(8'h40);
		chk(d, 32'h0);
		rbit(`AASY_OFS_STOPCAUSE, `AASY_STOP_ALARM, 32'h0);
		for (int p = 0; p < 2; p++) begin
			bus_wr(`AASY_OFS_ENV1, p << `AASY_ENV1_ALM_POL);
			alm_pol <= p[0];
			set_alarm(1'b1);
			repeat (4) @(posedge mclk);
			rbit(`AASY_OFS_SUBSTAT, `AASY_SUB_ALARM, 32'h1);
			set_alarm(1'b0);
			repeat (4) @(posedge mclk);
			rbit(`AASY_OFS_SUBSTAT, `AASY_SUB_ALARM, 32'h0);
		end
	endtask : t_reset

	task automatic t_alarm_stop;
		cmd(`AASY_CMD_START);
		wait_pe(1'b1, 3);
		set_alarm(1'b1);
		@(posedge mclk);
		#1 chk({31'h0, pulse_en}, 32'h1);
		wait_pe(1'b0, 5);
		rbit(`AASY_OFS_SUBSTAT, `AASY_SUB_ALARM, 32'h1);
		rbit(`AASY_OFS_STOPCAUSE, `AASY_STOP_ALARM, 32'h1);
		cmd(`AASY_CMD_START);
		repeat (3) @(posedge mclk);
		#1 chk({31'h0, pulse_en}, 32'h0);
		idle();
	endtask : t_alarm_stop

	task automatic t_decel;
		for (int sp = 0; sp < 2; sp++) begin
			bus_wr(`AASY_OFS_ENV1, 32'h00000300);
			bus_wr(`AASY_OFS_SPEED, sp);
			cmd(`AASY_CMD_START);
			wait_pe(1'b1, 3);
			set_alarm(1'b1);
			repeat (6) @(posedge mclk);
			#1 chk({31'h0, pulse_en}, sp);
			wait_pe(1'b0, 20);
			rbit(`AASY_OFS_STOPCAUSE, `AASY_STOP_ALARM, 32'h1);
			idle();
		end
	endtask : t_decel

	task automatic t_filter;
		bus_wr(`AASY_OFS_ENV1, 32'h04000200);
		bus_wr(`AASY_OFS_SPEED, 32'h0);
		cmd(`AASY_CMD_START);
		wait_pe(1'b1, 3);
		set_alarm(1'b1);
		repeat (40) @(posedge mclk);
		set_alarm(1'b0);
		repeat (4) @(posedge mclk);
		#1 chk({31'h0, pulse_en}, 32'h1);
		rbit(`AASY_OFS_SUBSTAT, `AASY_SUB_ALARM, 32'h0);
		set_alarm(1'b1);
		repeat (70) @(posedge mclk);
		#1 chk({31'h0, pulse_en}, 32'h1);
		wait_pe(1'b0, 20);
		idle();
	endtask : t_filter

	task automatic t_sync_cmd;
		int n;
		bus_wr(`AASY_OFS_ENV1, 32'h00000200);
		bus_wr(`AASY_OFS_MODE, 32'h00040000);
		bus_wr(`AASY_OFS_IRQ_EN, 32'h00040000);
		cmd(`AASY_CMD_START);
		bus_rd(`AASY_OFS_EXTSTAT);
		chk({26'h0, d[5:0]}, 32'h2);
		chk({31'h0, pulse_en}, 32'h0);
		cmd(`AASY_CMD_SYNC_START);
		n = 0;
		repeat (12) begin
			#1;
			if (line_oe === 1'b1 && line_o === 1'b0) n++;
			@(posedge mclk);
		end
		chk(n, 8);
		chk({30'h0, pulse_en, int_n}, 32'h2);
		rbit(`AASY_OFS_IRQ_CAUSE, `AASY_IRQ_START_CAUSE, 32'h1);
		bus_wr(`AASY_OFS_IRQ_CAUSE, 32'h00080000);
		repeat (2) @(posedge mclk);
		#1 chk({31'h0, int_n}, 32'h1);
		idle();
	endtask : t_sync_cmd

	task automatic t_level;
		@(posedge mclk);
		ext_low <= 1'b1;
		repeat (4) @(posedge mclk);
		rbit(`AASY_OFS_EXTSTAT, `AASY_EXT_START_LEVEL, 32'h1);
		cmd(`AASY_CMD_START);
		wait_pe(1'b1, 5);
		@(posedge mclk);
		ext_low <= 1'b0;
		idle();
		wait_pe(1'b0, 3);
	endtask : t_level

	task automatic t_edge;
		bus_wr(`AASY_OFS_ENV1, 32'h00040200);
		for (int k = 0; k < 2; k++) begin
			cmd(`AASY_CMD_START);
			bus_rd(`AASY_OFS_EXTSTAT);
			chk({28'h0, d[3:0]}, 32'h2);
			if (k == 0) begin
				cmd(`AASY_CMD_STOP_NOW);
				bus_rd(`AASY_OFS_EXTSTAT);
				chk({28'h0, d[3:0]}, 32'h0);
			end
			@(posedge mclk);
			ext_shot <= 1'b1;
			@(posedge mclk);
			ext_shot <= 1'b0;
			repeat (8) @(posedge mclk);
			#1 chk({31'h0, pulse_en}, k);
		end
		idle();
	endtask : t_edge

	// ==========================================================
	// Main sequence and hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			$display("ERROR %0t run did not finish", $time);
			close_out();
		end
	end

	initial begin
		mclk = 1'b0;
		rstn = 1'b0;
		wr_s = 1'b0;
		rd_s = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		alm_on = 1'b0;
		alm_pol = 1'b0;
		ext_low = 1'b0;
		ext_shot = 1'b0;
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		t_reset();
		t_alarm_stop();
		t_decel();
		t_filter();
		t_sync_cmd();
		t_level();
		t_edge();
		close_out();
	end
endmodule : test_axis_alarm_and_sync_start
